// file: logic/apc_pkg.sv
package apc_pkg;

	// ---------------------------------------------------------------
	// Link addressing
	// ---------------------------------------------------------------
	localparam logic [6:0] MEM_DEV       = 7'h50;
	localparam logic [6:0] REG_DEV       = 7'h54;
	localparam logic [7:0] MODE_CMD_ADDR = 8'hff;
	localparam logic [7:0] CMD_AUTO      = 8'ha0;
	localparam logic [7:0] CMD_ADJUST    = 8'ha7;
	localparam logic [7:0] CMD_MEMORY    = 8'hae;

	// ---------------------------------------------------------------
	// Device register space and fields
	// ---------------------------------------------------------------
	localparam int         REG_CNT        = 48;
	localparam int         MEM_CNT        = 128;
	localparam logic [7:0] LEVEL_CFG_ADDR = 8'h01;
	localparam logic [7:0] LOOP_CFG_ADDR  = 8'h02;
	localparam logic [7:0] GAIN_ADDR      = 8'h04;
	localparam logic [7:0] TARGET_ADDR    = 8'h0b;
	localparam logic [7:0] PASSWORD_ADDR  = 8'h2c;
	localparam logic [7:0] PROTECT_ADDR   = 8'h2d;
	localparam logic [7:0] LEVEL_SEL_ADDR = 8'h2f;
	localparam logic [6:0] STORED_PW_ADDR = 7'h7f;
	localparam int         FIRST_LVL_BIT  = 0;
	localparam int         COMPAT_BIT     = 1;
	localparam int         SECOND_LVL_BIT = 2;
	localparam int         FB_SEL_LSB     = 4;
	localparam int         FF_SEL_LSB     = 6;
	localparam int         GAIN_W         = 6;
	localparam logic [1:0] FB_OPEN_LOOP   = 2'h0;
	localparam logic [1:0] FF_OPEN_LOOP   = 2'h3;
	localparam logic [5:0] GAIN_MAX_CODE  = 6'h00;
	localparam logic       PROTECT_RST    = 1'b0;

	// ---------------------------------------------------------------
	// Host command port offsets
	// ---------------------------------------------------------------
	localparam logic [2:0] H_TARGET = 3'h0;
	localparam logic [2:0] H_ADDR   = 3'h1;
	localparam logic [2:0] H_WDATA  = 3'h2;
	localparam logic [2:0] H_CTRL   = 3'h3;
	localparam logic [2:0] H_STATUS = 3'h4;
	localparam logic [2:0] H_RDATA  = 3'h5;
	localparam int         CTRL_START_BIT   = 0;
	localparam int         CTRL_RELEASE_BIT = 1;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ         = 10000;
	localparam int AUTO_QUIET_US   = 2000;
	localparam int COMPAT_QUIET_US = 80000;
	localparam int AUTO_QUIET_CYC  = (AUTO_QUIET_US * CLK_KHZ + 999) / 1000;
	localparam int COMPAT_QUIET_CYC =
		(COMPAT_QUIET_US * CLK_KHZ + 999) / 1000;
	localparam int TIMER_W         = 20;

	typedef enum logic [1:0] {
		MODE_AUTO   = 2'b00,
		MODE_ADJUST = 2'b01,
		MODE_MEMORY = 2'b10
	} mode_e;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_REQ  = 2'b01,
		PH_WAIT = 2'b10
	} phase_e;

endpackage

// file: logic/apc_link.sv
interface apc_link;
	import apc_pkg::*;

	logic       req;
	logic       rd;
	logic [6:0] dev_addr;
	logic [7:0] reg_addr;
	logic [7:0] wdata;
	logic       wp_n;
	logic       ack;
	logic       nak;
	logic [7:0] rdata;

	modport host (
		output req, rd, dev_addr, reg_addr, wdata, wp_n,
		input  ack, nak, rdata
	);
	modport device (
		input  req, rd, dev_addr, reg_addr, wdata, wp_n,
		output ack, nak, rdata
	);
endinterface

// file: logic/hold_timer.sv
module hold_timer
	import apc_pkg::*;
#(
	parameter int   CYCLES        = 1,
	parameter logic BUSY_AT_RESET = 1'b0
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic start_i,
	output logic      busy_o
);

	typedef struct packed {
		logic [TIMER_W-1:0] cnt;
	} tmr_s;

	tmr_s s_r;
	tmr_s s_nxt;

	// Reload on start; a restart while running extends the hold
	always_comb begin
		s_nxt = s_r;
		if (start_i) begin
			s_nxt.cnt = TIMER_W'(CYCLES);
		end else if (s_r.cnt != '0) begin
			s_nxt.cnt = s_r.cnt - TIMER_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r.cnt <= BUSY_AT_RESET ? TIMER_W'(CYCLES) : '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy_o = (s_r.cnt != '0);

endmodule

// file: logic/apc_mode_device.sv
// Decided for this implementation: the plain strobed port and the register offsets.
module apc_mode_device
	import apc_pkg::*;
(
	// Clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	// Link to host
	apc_link.device    link,
	// Mode and status
	output mode_e      mode_o,
	output logic       protected_o,
	output logic       reload_o,
	output logic       comp_halt_o,
	// Loop settings
	output logic       open_loop_o,
	output logic       second_level_en_o,
	output logic [1:0] level_select_o,
	output logic [4:0] power_target_o,
	output logic       gain_max_o
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		mode_e                      mode;
		logic                       prot_ctrl;
		logic [REG_CNT-1:0][7:0]    regs;
		logic [MEM_CNT-1:0][7:0]    mem;
		logic                       ack;
		logic                       nak;
		logic [7:0]                 rdata;
		logic                       reload;
	} dev_s;

	dev_s s_r;
	dev_s s_nxt;

	logic prot;
	logic pw_match;
	logic is_mem;
	logic is_reg;
	logic ok;

	// Protection is the pin low or the control bit set
	assign prot     = !link.wp_n || s_r.prot_ctrl;
	assign pw_match = (s_r.regs[PASSWORD_ADDR[5:0]]
		== s_r.mem[STORED_PW_ADDR]);
	assign is_mem   = (link.dev_addr == MEM_DEV);
	assign is_reg   = (link.dev_addr == REG_DEV);

	// ---------------------------------------------------------------
	// Permission decode
	// ---------------------------------------------------------------
	function automatic logic grant(
		input mode_e      m,
		input logic       p,
		input logic       pin_hi,
		input logic       match,
		input logic       mem_acc,
		input logic       wr,
		input logic [7:0] a
	);
		logic in_reg;
		logic in_mem;
		logic reg_ok;
		in_reg = (a < 8'(REG_CNT)) || (a == PROTECT_ADDR)
			|| (a == MODE_CMD_ADDR);
		in_mem = (a < 8'(MEM_CNT));
		reg_ok = 1'b0;
		if (mem_acc) begin
			if (!in_mem) begin
				grant = 1'b0;
			end else if (p) begin
				grant = !wr;
			end else begin
				// Memory writes only in memory access mode
				grant = !wr || (m == MODE_MEMORY);
			end
		end else begin
			if (a == PASSWORD_ADDR && wr) begin
				reg_ok = pin_hi && (m == MODE_AUTO);
			end else if (a == PROTECT_ADDR && wr) begin
				reg_ok = pin_hi && (m == MODE_AUTO) && match;
			end else if (p) begin
				reg_ok = 1'b0;
			end else if (a == MODE_CMD_ADDR) begin
				reg_ok = wr;
			end else begin
				unique case (m)
					MODE_AUTO: begin
						reg_ok = !wr || (a == LEVEL_SEL_ADDR);
					end
					MODE_ADJUST: begin
						reg_ok = 1'b1;
					end
					MODE_MEMORY: begin
						reg_ok = 1'b0;
					end
					default: begin
						reg_ok = 1'b0;
					end
				endcase
			end
			grant = in_reg && reg_ok;
		end
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt        = s_r;
		s_nxt.ack    = 1'b0;
		s_nxt.nak    = 1'b0;
		s_nxt.reload = 1'b0;
		ok = grant(s_r.mode, prot, link.wp_n, pw_match, is_mem,
			!link.rd, link.reg_addr) && (is_mem || is_reg);
		// Protection pulls any other mode back to autonomous
		if (prot && s_r.mode != MODE_AUTO) begin
			s_nxt.mode   = MODE_AUTO;
			s_nxt.reload = 1'b1;
		end
		if (link.req) begin
			s_nxt.ack = ok;
			s_nxt.nak = !ok;
			if (ok && is_mem) begin
				if (link.rd) begin
					s_nxt.rdata = s_r.mem[link.reg_addr[6:0]];
				end else begin
					s_nxt.mem[link.reg_addr[6:0]] = link.wdata;
				end
			end else if (ok && link.reg_addr == MODE_CMD_ADDR) begin
				// Evaluated against protection through grant above
				unique case (link.wdata)
					CMD_AUTO: begin
						s_nxt.mode   = MODE_AUTO;
						s_nxt.reload = 1'b1;
					end
					CMD_ADJUST: begin
						s_nxt.mode = MODE_ADJUST;
					end
					CMD_MEMORY: begin
						s_nxt.mode = MODE_MEMORY;
					end
					default: begin
						s_nxt.ack = 1'b0; // Unknown code, mode kept
						s_nxt.nak = 1'b1;
					end
				endcase
			end else if (ok && link.reg_addr == PROTECT_ADDR) begin
				if (link.rd) begin
					s_nxt.rdata = {7'h00, s_r.prot_ctrl};
				end else begin
					s_nxt.prot_ctrl = link.wdata[0];
				end
			end else if (ok) begin
				if (link.rd) begin
					s_nxt.rdata = s_r.regs[link.reg_addr[5:0]];
				end else begin
					s_nxt.regs[link.reg_addr[5:0]] = link.wdata;
				end
			end
		end
	end

	// Memory contents start cleared; a real part would load them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r           <= '0;
			s_r.mode      <= MODE_AUTO;
			s_r.prot_ctrl <= PROTECT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign link.ack    = s_r.ack;
	assign link.nak    = s_r.nak;
	assign link.rdata  = s_r.rdata;
	assign mode_o      = s_r.mode;
	assign protected_o = prot;
	assign reload_o    = s_r.reload;
	assign comp_halt_o = (s_r.mode == MODE_ADJUST);

	// Loop and level decodes from the stored settings
	assign open_loop_o = (s_r.regs[LOOP_CFG_ADDR[5:0]][FB_SEL_LSB +: 2]
		== FB_OPEN_LOOP) && (s_r.regs[LOOP_CFG_ADDR[5:0]]
		[FF_SEL_LSB +: 2] == FF_OPEN_LOOP);
	assign second_level_en_o =
		!s_r.regs[LEVEL_CFG_ADDR[5:0]][FIRST_LVL_BIT]
		&& s_r.regs[LEVEL_CFG_ADDR[5:0]][SECOND_LVL_BIT];
	assign level_select_o = s_r.regs[LEVEL_SEL_ADDR[5:0]][1:0];
	assign power_target_o = s_r.regs[TARGET_ADDR[5:0]][4:0];
	assign gain_max_o     = (s_r.regs[GAIN_ADDR[5:0]][GAIN_W-1:0]
		== GAIN_MAX_CODE);

endmodule

// file: logic/apc_mode_host.sv
module apc_mode_host
	import apc_pkg::*;
#(
	parameter int AUTO_CYC   = AUTO_QUIET_CYC,
	parameter int COMPAT_CYC = COMPAT_QUIET_CYC
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Command port
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Link to device
	apc_link.host           link
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		phase_e     phase;
		logic [7:0] target;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       release_wp;
		logic       nak;
		logic       refused;
		logic [7:0] rdata;
		logic [7:0] urdata;
	} host_s;

	host_s s_r;
	host_s s_nxt;

	logic auto_busy;
	logic compat_busy;
	logic auto_go;
	logic compat_go;
	logic done_ok;
	logic quiet;
	logic start;
	logic is_cmd;

	assign quiet   = auto_busy || compat_busy;
	assign done_ok = (s_r.phase == PH_WAIT) && link.ack;
	assign is_cmd  = (s_r.target[6:0] == REG_DEV) && !s_r.target[7]
		&& (s_r.addr == MODE_CMD_ADDR);
	assign start   = wr_i && addr_i == H_CTRL && wdata_i[CTRL_START_BIT];
	// Quiet time after a successful return to autonomous mode
	assign auto_go = done_ok && is_cmd && s_r.wdata == CMD_AUTO;
	// Any accepted write of the level config may touch the compat bit
	assign compat_go = done_ok && (s_r.target[6:0] == REG_DEV)
		&& !s_r.target[7] && (s_r.addr == LEVEL_CFG_ADDR);

	// ---------------------------------------------------------------
	// Quiet-time timers
	// ---------------------------------------------------------------
	hold_timer #(
		.CYCLES        (AUTO_CYC),
		.BUSY_AT_RESET (1'b1)
	) u_auto_quiet (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (auto_go),
		.busy_o  (auto_busy)
	);

	hold_timer #(
		.CYCLES        (COMPAT_CYC),
		.BUSY_AT_RESET (1'b0)
	) u_compat_quiet (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.start_i (compat_go),
		.busy_o  (compat_busy)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		if (wr_i) begin
			unique case (addr_i)
				H_TARGET: s_nxt.target = wdata_i;
				H_ADDR:   s_nxt.addr = wdata_i;
				H_WDATA:  s_nxt.wdata = wdata_i;
				H_CTRL: begin
					s_nxt.release_wp = wdata_i[CTRL_RELEASE_BIT];
				end
				H_STATUS: begin
					// Write one to clear; a same-cycle set below wins
					s_nxt.nak     = s_r.nak && !wdata_i[1];
					s_nxt.refused = s_r.refused && !wdata_i[2];
				end
				default: begin
				end
			endcase
		end
		if (start) begin
			// Busy, quiet, or adjustment entry while still protected
			if (s_r.phase != PH_IDLE || quiet || (is_cmd
				&& s_r.wdata == CMD_ADJUST && !s_r.release_wp)) begin
				s_nxt.refused = 1'b1;
			end else begin
				s_nxt.phase = PH_REQ;
			end
		end
		unique case (s_r.phase)
			PH_IDLE: begin
			end
			PH_REQ: begin
				s_nxt.phase = PH_WAIT;
			end
			PH_WAIT: begin
				if (link.ack || link.nak) begin
					s_nxt.phase = PH_IDLE;
					// Keep a same-cycle clear unless a new refusal arrives
					s_nxt.nak   = s_nxt.nak || link.nak;
					if (link.ack && s_r.target[7]) begin
						s_nxt.rdata = link.rdata;
					end
				end
			end
			default: begin
				s_nxt.phase = PH_IDLE;
			end
		endcase
		// Command port read data, valid the cycle after the strobe
		s_nxt.urdata = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				H_TARGET: s_nxt.urdata = s_r.target;
				H_ADDR:   s_nxt.urdata = s_r.addr;
				H_WDATA:  s_nxt.urdata = s_r.wdata;
				H_CTRL:   s_nxt.urdata = {6'h00, s_r.release_wp, 1'b0};
				H_STATUS: s_nxt.urdata = {4'h0, quiet, s_r.refused,
					s_r.nak, s_r.phase != PH_IDLE};
				H_RDATA:  s_nxt.urdata = s_r.rdata;
				default:  s_nxt.urdata = 8'h00;
			endcase
		end
	end

	// Protection held on from reset until software releases it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r       <= '0;
			s_r.phase <= PH_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign rdata_o       = s_r.urdata;
	assign link.req      = (s_r.phase == PH_REQ);
	assign link.rd       = s_r.target[7];
	assign link.dev_addr = s_r.target[6:0];
	assign link.reg_addr = s_r.addr;
	assign link.wdata    = s_r.wdata;
	assign link.wp_n     = s_r.release_wp;

endmodule

// file: verif/apc_link_assertions.sv
module apc_link_assertions
	import apc_pkg::*;
#(
	parameter int AUTO_CYC   = AUTO_QUIET_CYC,
	parameter int COMPAT_CYC = COMPAT_QUIET_CYC
) (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Link signals
	input wire logic       req,
	input wire logic       rd,
	input wire logic [6:0] dev_addr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wdata,
	input wire logic       wp_n,
	input wire logic       ack,
	input wire logic       nak,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ---------------------------------------------------------------
	// Quiet window tracking
	// ---------------------------------------------------------------
	logic cmd_r;
	logic cfg_r;
	int   gap_r;
	int   lim_r;
	wire  reg_wr   = !rd && dev_addr == REG_DEV;
	wire  auto_cmd = reg_wr && reg_addr == MODE_CMD_ADDR && wdata == CMD_AUTO;
	wire  cfg_wr   = reg_wr && reg_addr == LEVEL_CFG_ADDR;
	wire  bad_cmd  = reg_wr && reg_addr == MODE_CMD_ADDR && wdata != CMD_AUTO
		&& wdata != CMD_ADJUST && wdata != CMD_MEMORY;

	// Window restarts only on an accepted trigger; saturates to avoid wrap
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r <= 1'b0;
			cfg_r <= 1'b0;
			gap_r <= 0;
			lim_r <= AUTO_CYC;
		end else begin
			if (req) begin
				cmd_r <= auto_cmd;
				cfg_r <= cfg_wr;
			end
			if (ack && (cmd_r || cfg_r)) begin
				gap_r <= 0;
				lim_r <= cmd_r ? AUTO_CYC : COMPAT_CYC;
			end else if (gap_r < 1000000) begin
				gap_r <= gap_r + 1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	sequence s_answer;
		##1 (ack ^ nak);
	endsequence
	sequence s_refused;
		##1 (nak && !ack);
	endsequence

	answer_once_a: assert property (req |-> s_answer)
		else $error("request not answered once");
	no_stray_a: assert property ((ack || nak) |-> $past(req))
		else $error("answer without request");
	single_req_a: assert property (req |=> !req)
		else $error("requests back to back");
	bad_cmd_a: assert property (req && bad_cmd |-> s_refused)
		else $error("unknown mode data accepted");
	prot_write_a: assert property (req && !wp_n && !rd |-> s_refused)
		else $error("write accepted while pin protected");
	prot_regrd_a: assert property (
		req && !wp_n && rd && dev_addr == REG_DEV |-> s_refused)
		else $error("register read accepted while protected");
	prot_memrd_a: assert property (req && !wp_n && rd && dev_addr == MEM_DEV
		&& !reg_addr[7] |=> ack && !nak)
		else $error("memory read refused while protected");
	adj_guard_a: assert property (!(req && !wp_n && reg_wr
		&& reg_addr == MODE_CMD_ADDR && wdata == CMD_ADJUST))
		else $error("adjust command sent while protected");
	quiet_gap_a: assert property (req |-> gap_r + 1 >= lim_r)
		else $error("request inside quiet window");
	rdata_hold_a: assert property (!$stable(rdata) |-> ack)
		else $error("read data changed without answer");
endmodule

// file: verif/tb_laser_apc_mode_control.sv
module tb_laser_apc_mode_control
	import apc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	localparam int AUTO_SIM   = 20;
	localparam int COMPAT_SIM = 50;
	logic       clk_i   = 1'b0;
	logic       rst_i   = 1'b1;
	logic [2:0] addr_i  = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic [7:0] rdata_o;
	mode_e      mode_o;
	logic       protected_o;
	logic       reload_o;
	logic       comp_halt_o;
	logic       open_loop_o;
	logic       second_level_en_o;
	logic [1:0] level_select_o;
	logic [4:0] power_target_o;
	logic       gain_max_o;
	logic       rel;
	logic [7:0] v;
	logic [7:0] n_reload = 8'h00;
	int         n_errors = 0;
	int         tests_run = 0;
	int         cyc = 0;

	apc_link link();
	apc_mode_host #(.AUTO_CYC(AUTO_SIM), .COMPAT_CYC(COMPAT_SIM))
	apc_mode_host_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.link(link));
	apc_mode_device apc_mode_device_i (.clk_i(clk_i), .rst_i(rst_i),
		.link(link), .mode_o(mode_o), .protected_o(protected_o),
		.reload_o(reload_o), .comp_halt_o(comp_halt_o),
		.open_loop_o(open_loop_o), .second_level_en_o(second_level_en_o),
		.level_select_o(level_select_o), .power_target_o(power_target_o),
		.gain_max_o(gain_max_o));
	apc_link_assertions #(.AUTO_CYC(AUTO_SIM), .COMPAT_CYC(COMPAT_SIM))
	apc_link_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .req(link.req),
		.rd(link.rd), .dev_addr(link.dev_addr), .reg_addr(link.reg_addr),
		.wdata(link.wdata), .wp_n(link.wp_n), .ack(link.ack),
		.nak(link.nak), .rdata(link.rdata));

	// Clock, cycle ceiling and count of autonomous entries
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (reload_o === 1'b1 && !rst_i)
			n_reload = n_reload + 8'h01;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic end_sim;
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Port tasks end at a falling edge so outputs have settled
	task automatic wr_port(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(negedge clk_i);
	endtask

	task automatic rd_port(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
	endtask

	task automatic set_rel(input logic r);
		wr_port(H_CTRL, {6'h00, r, 1'b0});
		rel = r;
	endtask

	// One link transfer; e is the expected {refused, nak} pair
	task automatic xfer(input logic r, input logic [6:0] dv,
		input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		logic [7:0] s;
		s = 8'h09;
		while (s[3] | s[0])
			rd_port(H_STATUS, s);
		wr_port(H_TARGET, {r, dv});
		wr_port(H_ADDR, a);
		wr_port(H_WDATA, d);
		wr_port(H_CTRL, {6'h00, rel, 1'b1});
		s = 8'h01;
		while (s[0])
			rd_port(H_STATUS, s);
		chk({6'h00, s[2:1]}, {6'h00, e});
		wr_port(H_STATUS, 8'h06);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] e);
		xfer(1'b0, REG_DEV, a, d, e);
	endtask

	task automatic cmd(input logic [7:0] d, input logic [1:0] e);
		reg_wr(MODE_CMD_ADDR, d, e);
	endtask

	task automatic rdchk(input logic [6:0] dv, input logic [7:0] a,
		input logic [7:0] exp);
		logic [7:0] d;
		xfer(1'b1, dv, a, 8'h00, 2'b00);
		rd_port(H_RDATA, d);
		chk(d, exp);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		rel = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({6'h00, mode_o}, {6'h00, MODE_AUTO});
		chk({7'h00, protected_o}, 8'h01);
		chk({7'h00, open_loop_o}, 8'h00);
		rdchk(MEM_DEV, 8'h00, 8'h00);
		xfer(1'b1, REG_DEV, LEVEL_SEL_ADDR, 8'h00, 2'b01);
		reg_wr(LEVEL_SEL_ADDR, 8'h01, 2'b01);
		cmd(CMD_AUTO, 2'b01);
		cmd(CMD_ADJUST, 2'b10);
		set_rel(1'b1);
		chk({7'h00, protected_o}, 8'h00);
		reg_wr(LEVEL_SEL_ADDR, 8'h02, 2'b00);
		chk({6'h00, level_select_o}, 8'h02);
		rdchk(REG_DEV, LEVEL_SEL_ADDR, 8'h02);
		reg_wr(TARGET_ADDR, 8'h10, 2'b01);
		xfer(1'b0, MEM_DEV, 8'h10, 8'h33, 2'b01);
		cmd(CMD_ADJUST, 2'b00);
		chk({6'h00, mode_o}, {6'h00, MODE_ADJUST});
		chk({7'h00, comp_halt_o}, 8'h01);
		// Target is centred before the loop is configured
		reg_wr(TARGET_ADDR, 8'h10, 2'b00);
		chk({3'h0, power_target_o}, 8'h10);
		reg_wr(GAIN_ADDR, 8'h01, 2'b00);
		chk({7'h00, gain_max_o}, 8'h00);
		reg_wr(GAIN_ADDR, 8'h00, 2'b00);
		chk({7'h00, gain_max_o}, 8'h01);
		reg_wr(LOOP_CFG_ADDR, 8'hc0, 2'b00);
		chk({7'h00, open_loop_o}, 8'h01);
		rdchk(REG_DEV, TARGET_ADDR, 8'h10);
		reg_wr(LEVEL_CFG_ADDR, 8'h04, 2'b00);
		chk({7'h00, second_level_en_o}, 8'h01);
		xfer(1'b0, MEM_DEV, 8'h10, 8'h33, 2'b01);
		cmd(CMD_AUTO, 2'b00);
		chk(n_reload, 8'h01);
		chk({7'h00, comp_halt_o}, 8'h00);
		// A start inside the quiet window must be refused, no request
		wr_port(H_CTRL, {6'h00, rel, 1'b1});
		rd_port(H_STATUS, v);
		chk(v, 8'h0c);
		wr_port(H_STATUS, 8'h06);
		cmd(CMD_MEMORY, 2'b00);
		chk({6'h00, mode_o}, {6'h00, MODE_MEMORY});
		xfer(1'b0, MEM_DEV, {1'b0, STORED_PW_ADDR}, 8'h5a, 2'b00);
		rdchk(MEM_DEV, {1'b0, STORED_PW_ADDR}, 8'h5a);
		xfer(1'b1, REG_DEV, TARGET_ADDR, 8'h00, 2'b01);
		cmd(8'h55, 2'b01);
		chk({6'h00, mode_o}, {6'h00, MODE_MEMORY});
		cmd(CMD_AUTO, 2'b00);
		chk(n_reload, 8'h02);
		reg_wr(PROTECT_ADDR, 8'h01, 2'b01);
		reg_wr(PASSWORD_ADDR, 8'h5a, 2'b00);
		reg_wr(PROTECT_ADDR, 8'h01, 2'b00);
		chk({7'h00, protected_o}, 8'h01);
		cmd(CMD_ADJUST, 2'b01);
		chk({6'h00, mode_o}, {6'h00, MODE_AUTO});
		reg_wr(LEVEL_SEL_ADDR, 8'h01, 2'b01);
		reg_wr(PASSWORD_ADDR, 8'h5a, 2'b00);
		reg_wr(PROTECT_ADDR, 8'h00, 2'b00);
		chk({7'h00, protected_o}, 8'h00);
		cmd(CMD_ADJUST, 2'b00);
		set_rel(1'b0);
		rd_port(H_CTRL, v);
		chk(v, 8'h00);
		chk({6'h00, mode_o}, {6'h00, MODE_AUTO});
		chk(n_reload, 8'h03);
		end_sim();
	end
endmodule
